// >>> src/wkc_top.sv
// wake input configuration registers, pin roles, pulls and wake filters
//
// Notes on behaviour
// - bits 7:6 of external wake control ignore writes and read as zero.
// - measurement select set removes wake inputs 1 and 2 as wake sources.
// - measurement function runs on inputs 1 and 2 only in normal state.
// - measurement select clear keeps inputs 1 and 2 as ordinary wakes.
// - measurement select resets to zero.
// - bit 4 zero makes pin four a wake input, one a sync input.
// - wake role of pin four is default and wins unless sync chosen.
// - bits 3:0 enable inputs 4..1; reset leaves 1 to 3 enabled.
// - transceiver wake sources are not enabled by this register.
// - fail-safe entry forces 000x 0111, keeping the sync-select bit.
// - two-bit pull field per input: none, down, up, automatic.
// - pin four in sync role outside sleep state uses pull-down regardless of its field.
// - pin four applies no pull selection in sleep state.
// - filter codes 00 and 01 give 16us and 64us static sensing.
// - codes 10 and 11 sense cyclically after timer settle, 16us filter.
`timescale 1ns/1ps
module wkc_top
    import wkc_pkg::*;
#(
    parameter int unsigned P_FLT_LONG_CYC = FLT_LONG_CYC_DEF
)
(
    input  wire logic            i_core_clk,
    input  wire logic            i_rstn,
    input  wire wkc_pkg::wkc_reg_req_t    i_reg_req,
    input  wire wkc_pkg::wkc_chip_state_t i_chip_state,
    input  wire logic [3:0]      i_wake_pin,
    input  wire logic [1:0]      i_timer_settled,
    output logic [7:0]           o_reg_rdata,
    output logic [3:0]           o_wake_event,
    output logic                 o_meas_enable,
    output logic [7:0]           o_pull_sel,
    output logic                 o_sync_role,
    output logic                 o_sync_level
);
    import wkc_pkg::*;

    localparam logic [CNT_W-1:0] LEN_SHORT = CNT_W'(FLT_SHORT_CYC);
    localparam logic [CNT_W-1:0] LEN_LONG  = CNT_W'(P_FLT_LONG_CYC);

    wkc_top_st_t      st_r;
    wkc_top_st_t      st_nxt;
    logic [3:0]       wake_role;
    logic [3:0]       wake_en;
    logic [3:0]       sense_ok;
    logic [3:0]       flt_evt;
    logic [CNT_W-1:0] flt_len [4];

    // pin roles: measurement takes inputs 1 and 2, sync takes pin four
    always_comb begin
        wake_role    = 4'hf;
        wake_role[0] = ~st_r.ewc[EWC_MEAS_BIT];
        wake_role[1] = ~st_r.ewc[EWC_MEAS_BIT];
        wake_role[3] = ~st_r.ewc[EWC_SYNC_BIT];
        // only pin enables feed wake here, transceivers wake elsewhere
        wake_en      = st_r.ewc[3:0] & wake_role;
    end

    // per-input filter selection and filter instances
    generate
        for (genvar g = 0; g < 4; g++) begin : g_in
            logic [1:0] code;
            assign code = st_r.flt[2*g +: 2];
            // static codes always sense, cyclic codes wait for timer settle
            assign sense_ok[g] = (code == FLT_CYC_T1) ? i_timer_settled[0] :
                                 (code == FLT_CYC_T2) ? i_timer_settled[1] :
                                 1'b1;
            assign flt_len[g]  = (code == FLT_STAT_LONG) ? LEN_LONG : LEN_SHORT;

            wkc_filter u_flt (
                .i_core_clk (i_core_clk),
                .i_rstn     (i_rstn),
                .i_level    (st_r.sync2[g]),
                .i_enable   (wake_en[g]),
                .i_sense_ok (sense_ok[g]),
                .i_len      (flt_len[g]),
                .o_event    (flt_evt[g])
            );
        end
    endgenerate

    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = i_wake_pin;
        st_nxt.sync2 = st_r.sync1;

        // register writes; reserved bits stay zero
        if (i_reg_req.wr) begin
            case (i_reg_req.addr)
                ADDR_EWC:  st_nxt.ewc  = i_reg_req.wdata & EWC_WMASK;
                ADDR_PULL: st_nxt.pull = i_reg_req.wdata;
                ADDR_FLT:  st_nxt.flt  = i_reg_req.wdata;
                default:   st_nxt.ewc  = st_r.ewc;
            endcase
        end

        // fail-safe entry overrides a same-cycle write
        if (i_chip_state.fail_safe_entry) begin
            st_nxt.ewc = EWC_FS_VAL | (st_r.ewc & EWC_FS_KEEP);
        end

        // register reads, answered one cycle later; unmapped reads zero
        if (i_reg_req.rd) begin
            case (i_reg_req.addr)
                ADDR_EWC:  st_nxt.rdata = st_r.ewc & EWC_WMASK;
                ADDR_PULL: st_nxt.rdata = st_r.pull;
                ADDR_FLT:  st_nxt.rdata = st_r.flt;
                default:   st_nxt.rdata = RD_NONE;
            endcase
        end

        st_nxt.meas_en = st_r.ewc[EWC_MEAS_BIT] & i_chip_state.normal;

        // effective pull selection per input
        st_nxt.pull_out = st_r.pull;
        if (i_chip_state.sleep) begin
            st_nxt.pull_out[7:6] = PULL_NONE;
        end else if (st_r.ewc[EWC_SYNC_BIT]) begin
            st_nxt.pull_out[7:6] = PULL_DOWN;
        end

        st_nxt.evt        = flt_evt;
        st_nxt.sync_role  = st_r.ewc[EWC_SYNC_BIT];
        st_nxt.sync_level = st_r.ewc[EWC_SYNC_BIT] & st_r.sync2[3];
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r          <= '0;
            st_r.ewc      <= EWC_RST;
            st_r.pull     <= PULL_RST;
            st_r.flt      <= FLT_RST;
            st_r.pull_out <= PULL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata   = st_r.rdata;
    assign o_wake_event  = st_r.evt;
    assign o_meas_enable = st_r.meas_en;
    assign o_pull_sel    = st_r.pull_out;
    assign o_sync_role   = st_r.sync_role;
    assign o_sync_level  = st_r.sync_level;

    a_rsv_bits_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        st_r.ewc[7:6] == 2'b00)
        else $error("reserved wake control bits not zero");

    a_ewc_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_reg_req.wr && i_reg_req.addr == ADDR_EWC && !i_chip_state.fail_safe_entry)
        |=> st_r.ewc == ($past(i_reg_req.wdata) & EWC_WMASK))
        else $error("wake control write not stored");

    a_meas_no_wake: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ($past(st_r.ewc[EWC_MEAS_BIT], 2) && $past(st_r.ewc[EWC_MEAS_BIT]))
        |-> o_wake_event[1:0] == 2'b00)
        else $error("wake on measurement input");

    a_meas_normal: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ##1 o_meas_enable == ($past(st_r.ewc[EWC_MEAS_BIT]) && $past(i_chip_state.normal)))
        else $error("measurement enable mismatch");

    a_fail_safe: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_chip_state.fail_safe_entry
        |=> st_r.ewc == {3'b000, $past(st_r.ewc[EWC_SYNC_BIT]), 4'b0111})
        else $error("fail-safe value not forced");

    a_sync_pull: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (st_r.ewc[EWC_SYNC_BIT] && !i_chip_state.sleep) |=> o_pull_sel[7:6] == PULL_DOWN)
        else $error("sync pin not pulled down");

    a_sleep_pull: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_chip_state.sleep |=> o_pull_sel[7:6] == PULL_NONE)
        else $error("pin four pull active in sleep");

    a_pin4_sync_wake: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        ($past(st_r.ewc[EWC_SYNC_BIT], 2) && $past(st_r.ewc[EWC_SYNC_BIT]))
        |-> !o_wake_event[3])
        else $error("wake from pin four in sync role");

    a_rd_unmapped: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (i_reg_req.rd && i_reg_req.addr != ADDR_EWC && i_reg_req.addr != ADDR_PULL
         && i_reg_req.addr != ADDR_FLT) |=> o_reg_rdata == RD_NONE)
        else $error("unmapped read not zero");
endmodule

// >>> src/wkc_pkg.sv
// constants and carrier types for the wake input configuration block
package wkc_pkg;
    // clock and filter timing
    localparam int unsigned CLK_PERIOD_PS    = 8000;
    localparam int unsigned FLT_SHORT_US     = 16;
    localparam int unsigned FLT_LONG_US      = 64;
    localparam int unsigned FLT_SHORT_CYC    = (FLT_SHORT_US * 1000000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int unsigned FLT_LONG_CYC_DEF = (FLT_LONG_US * 1000000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int unsigned CNT_W            = 13;

    // register addresses on the serial register port
    localparam logic [6:0] ADDR_EWC  = 7'h07;
    localparam logic [6:0] ADDR_PULL = 7'h08;
    localparam logic [6:0] ADDR_FLT  = 7'h09;

    // reset values
    localparam logic [7:0] EWC_RST  = 8'h07;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] FLT_RST  = 8'h00;

    // external wake control fields
    localparam int unsigned EWC_MEAS_BIT = 5;
    localparam int unsigned EWC_SYNC_BIT = 4;
    localparam logic [7:0]  EWC_WMASK    = 8'h3f;
    localparam logic [7:0]  EWC_FS_VAL   = 8'h07;
    localparam logic [7:0]  EWC_FS_KEEP  = 8'h10;
    localparam logic [7:0]  RD_NONE      = 8'h00;

    // pull field codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // filter field codes
    localparam logic [1:0] FLT_STAT_SHORT = 2'h0;
    localparam logic [1:0] FLT_STAT_LONG  = 2'h1;
    localparam logic [1:0] FLT_CYC_T1     = 2'h2;
    localparam logic [1:0] FLT_CYC_T2     = 2'h3;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } wkc_reg_req_t;

    typedef struct packed {
        logic normal;
        logic sleep;
        logic fail_safe_entry;
    } wkc_chip_state_t;

    typedef struct packed {
        logic             stable;
        logic [CNT_W-1:0] cnt;
        logic             evt;
    } wkc_flt_st_t;

    typedef struct packed {
        logic [7:0] ewc;
        logic [7:0] pull;
        logic [7:0] flt;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [7:0] rdata;
        logic       meas_en;
        logic [7:0] pull_out;
        logic [3:0] evt;
        logic       sync_role;
        logic       sync_level;
    } wkc_top_st_t;
endpackage

// >>> src/wkc_filter.sv
// level-change filter for one wake input
`timescale 1ns/1ps
module wkc_filter
    import wkc_pkg::*;
(
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_level,
    input  wire logic             i_enable,
    input  wire logic             i_sense_ok,
    input  wire logic [CNT_W-1:0] i_len,
    output logic                  o_event
);
    wkc_flt_st_t st_r;
    wkc_flt_st_t st_nxt;

    // a change must hold for i_len sampled cycles before it is accepted
    always_comb begin
        st_nxt     = st_r;
        st_nxt.evt = 1'b0;
        if (!i_sense_ok || (i_level == st_r.stable)) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == i_len - 1'b1) begin
            st_nxt.stable = i_level;
            st_nxt.cnt    = '0;
            st_nxt.evt    = i_enable;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_event = st_r.evt;

    a_evt_full_time: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_event |-> $past(st_r.cnt) == $past(i_len) - 1'b1 && $past(i_enable))
        else $error("wake event without full filter time");
endmodule

// >>> verif/wkc_wake_sw.sv
// wake switch and sensor model on the four wake pins
`timescale 1ns/1ps
module wkc_wake_sw (
    input  wire logic       i_core_clk,
    input  wire logic [3:0] i_close,
    input  wire logic [7:0] i_pull_sel,
    output logic [3:0]      o_pin
);
    logic toggle_r = 1'b0;
    always @(posedge i_core_clk) toggle_r <= ~toggle_r;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            case (i_pull_sel[2*k +: 2])  // open switch settles to the pull level, toggles with no pull
                2'h2:    o_pin[k] = 1'b1;
                2'h0:    o_pin[k] = toggle_r ^ k[0];
                default: o_pin[k] = 1'b0;
            endcase
            if (i_close[k]) o_pin[k] = 1'b1;
        end
    end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the wake input configuration block
`timescale 1ns/1ps
module testbench;
    import wkc_pkg::*;
    localparam int unsigned LONG = 40;
    logic            i_core_clk  = 1'b0;
    logic            i_rstn      = 1'b0;
    wkc_reg_req_t    req         = '0;
    wkc_chip_state_t st          = '0;
    logic [1:0]      settled     = 2'h0;
    logic [3:0]      close       = 4'h0;
    logic [3:0]      pin;
    logic [7:0]      rdata;
    logic [7:0]      pull_sel;
    logic [3:0]      evt;
    logic            meas;
    logic            sync_role;
    logic            sync_level;
    logic [9:0]      blk [4]     = '{{8'h2f, 2'h0}, {8'h2f, 2'h1}, {8'h0e, 2'h0}, {8'h17, 2'h3}};
    int              failures    = 0;
    int              comparisons = 0;
    int              n;
    always #4 i_core_clk = ~i_core_clk;
    wkc_top #(.P_FLT_LONG_CYC(LONG)) wkc_top_inst (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_req(req), .i_chip_state(st),
        .i_wake_pin(pin), .i_timer_settled(settled), .o_reg_rdata(rdata),
        .o_wake_event(evt), .o_meas_enable(meas), .o_pull_sel(pull_sel),
        .o_sync_role(sync_role), .o_sync_level(sync_level));
    wkc_wake_sw wkc_wake_sw_inst (.i_core_clk(i_core_clk), .i_close(close),
        .i_pull_sel(pull_sel), .o_pin(pin));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        req.wr = 1'b1; req.addr = a; req.wdata = d;
        @(negedge i_core_clk);
        req.wr = 1'b0;
        // idle cycle so a following request never re-raises in this step
        @(negedge i_core_clk);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        req.rd = 1'b1; req.addr = a;
        @(negedge i_core_clk);
        req.rd = 1'b0;
        chk(rdata, exp);
        @(negedge i_core_clk);
    endtask
    task automatic pulse_fs();
        st.fail_safe_entry = 1'b1;
        @(negedge i_core_clk);
        st.fail_safe_entry = 1'b0;
    endtask
    task automatic wait_evt(input int idx, input int lim, input bit must);
        n = 0;
        while (n < lim && evt[idx] !== 1'b1) begin
            @(negedge i_core_clk);
            n++;
        end
        if (must && n == lim) begin
            failures++;
            $display("Error at %0t: wake event never came", $time);
            conclude();
        end
        @(negedge i_core_clk);
    endtask
    task automatic flip(input int idx, input int lim, input bit must);
        close[idx] = ~close[idx];
        wait_evt(idx, lim, must);
    endtask
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_rstn = 1'b1;
        chk(sync_role, 0);
        rdc(ADDR_EWC, 8'h07);
        rdc(ADDR_PULL, 8'h00);
        rdc(ADDR_FLT, 8'h00);
        wr(ADDR_EWC, 8'hff);
        rdc(ADDR_EWC, 8'h3f);
        rdc(7'h0a, 8'h00);
        $display("test registers done");
        st.normal = 1'b1;
        @(negedge i_core_clk);
        chk(meas, 1);
        st.normal = 1'b0;
        @(negedge i_core_clk);
        chk(meas, 0);
        chk(sync_role, 1);
        wr(ADDR_PULL, 8'he4);
        @(negedge i_core_clk);
        chk(pull_sel, 8'h64);
        st.sleep = 1'b1;
        @(negedge i_core_clk);
        chk(pull_sel, 8'h24);
        st.sleep = 1'b0;
        close[3] = 1'b1;
        repeat (4) @(negedge i_core_clk);
        chk(sync_level, 1);
        close[3] = 1'b0;
        wr(ADDR_EWC, 8'h3a);
        pulse_fs();
        rdc(ADDR_EWC, 8'h17);
        wr(ADDR_EWC, 8'h20);
        pulse_fs();
        rdc(ADDR_EWC, 8'h07);
        $display("test roles and fail-safe done");
        wr(ADDR_PULL, 8'h55);
        wr(ADDR_FLT, 8'h55);
        wr(ADDR_EWC, 8'h0f);
        repeat (2100) @(negedge i_core_clk);
        for (int i = 0; i < 4; i++) begin
            flip(i, LONG + 20, 1);
            chk(n inside {[LONG - 2 : LONG + 8]}, 1);
            flip(i, LONG + 20, 1);
        end
        foreach (blk[j]) begin
            wr(ADDR_EWC, blk[j][9:2]);
            flip(blk[j][1:0], LONG + 20, 0);
            chk(n, LONG + 20);
            flip(blk[j][1:0], LONG + 20, 0);
        end
        $display("test long filter and wake gating done");
        wr(ADDR_EWC, 8'h0f);
        wr(ADDR_FLT, 8'h00);
        flip(2, 2100, 1);
        chk(n inside {[1998 : 2008]}, 1);
        flip(2, 2100, 1);
        // cyclic timers are taken as assigned to a high-side switch
        settled = 2'h1;
        wr(ADDR_FLT, 8'h0c);
        flip(1, 2100, 0);
        chk(n, 2100);
        settled = 2'h3;
        wait_evt(1, 2100, 1);
        flip(1, 2100, 1);
        settled = 2'h2;
        wr(ADDR_FLT, 8'h08);
        flip(1, 2100, 0);
        chk(n, 2100);
        settled = 2'h3;
        wait_evt(1, 2100, 1);
        chk(evt, 4'h0);
        $display("test short and cyclic filters done");
        conclude();
    end
endmodule
